// ===== inc/srcm_pkg.sv
// srcm_pkg: constants and carrier types for the servo remote command map.
// assumes a single 100 MHz pclk domain and an APB master with 32-bit data.
package srcm_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 10;

   // station window: each station owns a block of word registers
   localparam int          STATION_W     = 4;
   localparam int          WIN_W         = 5;
   localparam logic [9:0]  STATION_WORDS = 10'h020;

   // word indexes inside a station window (byte address = 4 * index)
   localparam logic [4:0] IDX_WW0  = 5'h00; // master write words 0..7
   localparam logic [4:0] IDX_RW0  = 5'h08; // driver read words 0..7
   localparam logic [4:0] IDX_RY   = 5'h10; // remote output bits
   localparam logic [4:0] IDX_RX   = 5'h11; // remote input bits
   localparam logic [4:0] IDX_CSS  = 5'h12; // command source setting
   localparam logic [4:0] IDX_CTRL = 5'h13; // operation mode control

   // write word numbers
   localparam int WW_MON1 = 0;
   localparam int WW_MON2 = 1;
   localparam int WW_INSTR = 2;
   localparam int WW_WDATA = 3;
   localparam int WW_POS_LO = 4;
   localparam int WW_POS_HI = 5;
   localparam int WW_SPEED = 6;

   // read word numbers
   localparam int RW_MON1_LO = 0;
   localparam int RW_MON1_HI = 1;
   localparam int RW_RESP = 2;
   localparam int RW_RDATA = 3;
   localparam int RW_MON2_LO = 5;
   localparam int RW_MON2_HI = 6;

   // remote output bit positions (low half RYn, high half RY(n+2))
   localparam int RY_PWR     = 0;
   localparam int RY_FWD     = 1;
   localparam int RY_REV     = 2;
   localparam int RY_POS_REQ = 16;
   localparam int RY_SPD_REQ = 17;

   // remote input bit positions
   localparam int RX_READY    = 0;
   localparam int RX_MOVE_END = 12;
   localparam int RX_POS_DONE = 16;
   localparam int RX_SPD_DONE = 17;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_INC      = 2;

   // reset values
   localparam logic [31:0] RY_RST   = 32'h0000_0000;
   localparam logic [15:0] CSS_RST  = 16'h0000;
   localparam logic [2:0]  CTRL_RST = 3'h0;
   localparam logic [15:0] WW_RST   = 16'h0000;

   // low digit codes of the command source setting
   localparam logic [3:0] CSS_TABLE = 4'h0;
   localparam logic [3:0] CSS_POS   = 4'h1;
   localparam logic [3:0] CSS_SPEED = 4'h2;

   // point table entry holding accel/decel constants in speed mode
   localparam logic [7:0] ACCEL_TABLE_ENTRY = 8'h01;

   typedef enum logic [1:0] {
      SRCM_OP_AUTO,
      SRCM_OP_HOME,
      SRCM_OP_JOG
   } srcm_op_t;

   // command bundle towards the motion controller
   typedef struct packed {
      logic        move_start;
      logic        move_rev;
      logic        move_abs;
      logic        home_start;
      logic        home_fast;
      logic        jog_fwd;
      logic        jog_rev;
      logic [31:0] target;
      logic [15:0] speed;
      logic        speed_valid;
      logic [7:0]  table_no;
      logic [7:0]  accel_table;
   } srcm_motion_t;

   // status and monitor bundle from the motion controller
   typedef struct packed {
      logic        move_end;
      logic [31:0] mon1_data;
      logic [31:0] mon2_data;
      logic [15:0] resp_code;
      logic [15:0] read_data;
   } srcm_status_t;

endpackage

// ===== rtl/srcm_sync2.sv
// srcm_sync2: two-flop synchroniser for a bus of slow levels.
// assumes the input changes rarely; bits may land one cycle apart.
`timescale 1ns/100ps
module srcm_sync2
   import srcm_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ===== rtl/srcm_core.sv
// srcm_core: remote word and bit map of a fieldbus servo driver, APB slave.
// assumes the station number strap is static and the motion side is on pclk.
//
// Behaviour
// R1: register window base is offset by the strapped station number.
// R2: master puts a 32-bit monitor's code in the low 16 bits.
// R3: monitor 1 value returns in read words 0 (low) and 1 (high).
// R4: monitor 2 value returns in read words 5 (low) and 6 (high).
// R5: setting digit 0: master puts point table number in word 4.
// R6: setting digit 1 or 2: position in words 4/5, then position request.
// R7: setting digit 1: master puts point table number in word 6.
// R8: setting digit 2: speed in word 6, then speed request bit.
// R9: setting digit 2: accel/decel always come from table entry 1.
// R10: setting digit 0: word 6 is ignored.
// R11: power stage bit energises the stage; clearing it lets the motor coast.
// R12: absolute mode, forward start in automatic runs one move to target.
// R13: home mode, forward start begins home return at once.
// R14: jog mode, forward rotation while the forward start bit is held.
// R15: incremental mode, forward start in automatic runs one forward move.
// R16: incremental mode, reverse start in automatic runs one reverse move.
// R17: jog mode, reverse rotation while the reverse start bit is held.
// R18: home mode, reverse start triggers the high-speed return to home.
// R19: position instruction completion is reported in the read bits.
// R20: moves launch on the rising edge of a start bit only.
`timescale 1ns/100ps
module srcm_core
   import srcm_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [STATION_W-1:0] station_no,
   input  wire srcm_status_t         status,
   output logic                      power_stage_on,
   output logic      [15:0]          mon1_code,
   output logic      [15:0]          mon2_code,
   output logic      [15:0]          instr_code,
   output logic      [15:0]          instr_wdata,
   output srcm_motion_t              motion
);

   logic [STATION_W-1:0] station_sync;
   logic [STATION_W-1:0] station_reg;
   logic                 station_ok_reg;
   logic [1:0]           settle_reg;
   logic [15:0]          ww_reg [0:7];
   logic [15:0]          rw_reg [0:7];
   logic [31:0]          ry_reg;
   logic [31:0]          rx_reg;
   logic [15:0]          css_reg;
   logic [2:0]           ctrl_reg;
   logic                 fwd_d_reg;
   logic                 rev_d_reg;
   logic                 posreq_d_reg;
   logic                 spdreq_d_reg;
   logic [9:0]           word_idx;
   logic [9:0]           base_idx;
   logic [9:0]           rel_idx;
   logic                 in_window;
   logic [4:0]           loc;
   logic                 setup_ph;
   logic                 wr_acc;
   logic [31:0]          rd_next;
   logic                 err_next;
   logic [3:0]           css_digit;
   srcm_op_t             op_mode;
   logic                 inc_mode;
   logic                 fwd_rise;
   logic                 rev_rise;
   logic                 posreq_rise;
   logic                 spdreq_rise;
   logic                 stage_on;

   // station strap crosses in through two flops
   srcm_sync2 #(
      .WIDTH    (STATION_W)
   ) u_station_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (station_no),
      .sync_out (station_sync)
   );

   // catch the station number once, after the synchroniser has settled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_reg     <= 2'h0;
         station_reg    <= '0;
         station_ok_reg <= 1'b0;
      end else begin
         settle_reg <= {settle_reg[0], 1'b1}; // two edges for the synchroniser
         if (settle_reg[1] && !station_ok_reg) begin
            station_reg    <= station_sync; // see R1
            station_ok_reg <= 1'b1;
         end
      end
   end

   // address decode relative to the station base
   assign word_idx  = paddr[11:2];
   assign base_idx  = 10'(station_reg) * STATION_WORDS; // see R1
   assign rel_idx   = word_idx - base_idx;
   assign in_window = (word_idx >= base_idx) && (rel_idx < STATION_WORDS);
   assign loc       = rel_idx[WIN_W-1:0];
   assign setup_ph  = psel && !penable;
   assign wr_acc    = psel && penable && pwrite && in_window;

   // decoded fields of the software settings
   assign css_digit = css_reg[3:0];
   assign inc_mode  = ctrl_reg[CTRL_INC];
   assign stage_on  = ry_reg[RY_PWR];

   // operation mode from the control register
   always_comb begin
      case (ctrl_reg[CTRL_MODE_LSB +: 2])
         2'h1:    op_mode = SRCM_OP_HOME;
         2'h2:    op_mode = SRCM_OP_JOG;
         default: op_mode = SRCM_OP_AUTO;
      endcase
   end

   // read mux and unmapped check, evaluated in the setup phase
   always_comb begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      if (!in_window) begin
         err_next = 1'b1;
      end else if (loc < IDX_RW0) begin
         rd_next = {16'h0000, ww_reg[loc[2:0]]};
      end else if (loc < IDX_RY) begin
         rd_next = {16'h0000, rw_reg[loc[2:0]]};
      end else if (loc == IDX_RY) begin
         rd_next = ry_reg;
      end else if (loc == IDX_RX) begin
         rd_next = rx_reg;
      end else if (loc == IDX_CSS) begin
         rd_next = {16'h0000, css_reg};
      end else if (loc == IDX_CTRL) begin
         rd_next = {29'h0000_0000, ctrl_reg};
      end else begin
         err_next = 1'b1;
      end
   end

   // read data and error are registered at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_next;
         pslverr <= err_next;
      end
   end

   // one wait-free access phase after the registered setup
   assign pready = 1'b1;

   // master write words, taken at the access edge
   generate
      for (genvar w = 0; w < 8; w++) begin : g_ww
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ww_reg[w] <= WW_RST;
            end else if (wr_acc && loc == (IDX_WW0 + 5'(w))) begin
               ww_reg[w] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   // remote output bits, command source setting and mode control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ry_reg   <= RY_RST;
         css_reg  <= CSS_RST;
         ctrl_reg <= CTRL_RST;
      end else if (wr_acc) begin
         if (loc == IDX_RY) begin
            ry_reg <= pwdata;
         end else if (loc == IDX_CSS) begin
            css_reg <= pwdata[15:0];
         end else if (loc == IDX_CTRL) begin
            ctrl_reg <= pwdata[2:0];
         end
      end
   end

   // monitor and instruction words forwarded to the driver core
   assign mon1_code   = ww_reg[WW_MON1]; // see R2
   assign mon2_code   = ww_reg[WW_MON2];
   assign instr_code  = ww_reg[WW_INSTR];
   assign instr_wdata = ww_reg[WW_WDATA];

   // read words refreshed every cycle from the driver core, words 4 and 7 held at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) begin
            rw_reg[i] <= WW_RST;
         end
      end else begin
         rw_reg[RW_MON1_LO] <= status.mon1_data[15:0];  // see R3
         rw_reg[RW_MON1_HI] <= status.mon1_data[31:16]; // see R3
         rw_reg[RW_RESP]    <= status.resp_code;
         rw_reg[RW_RDATA]   <= status.read_data;
         rw_reg[4]          <= WW_RST;
         rw_reg[RW_MON2_LO] <= status.mon2_data[15:0];  // see R4
         rw_reg[RW_MON2_HI] <= status.mon2_data[31:16]; // see R4
         rw_reg[7]          <= WW_RST;
      end
   end

   // previous values for edge detection of start and request bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_d_reg    <= 1'b0;
         rev_d_reg    <= 1'b0;
         posreq_d_reg <= 1'b0;
         spdreq_d_reg <= 1'b0;
      end else begin
         fwd_d_reg    <= ry_reg[RY_FWD];
         rev_d_reg    <= ry_reg[RY_REV];
         posreq_d_reg <= ry_reg[RY_POS_REQ];
         spdreq_d_reg <= ry_reg[RY_SPD_REQ];
      end
   end

   assign fwd_rise    = ry_reg[RY_FWD] && !fwd_d_reg;         // see R20
   assign rev_rise    = ry_reg[RY_REV] && !rev_d_reg;         // see R20
   assign posreq_rise = ry_reg[RY_POS_REQ] && !posreq_d_reg;
   assign spdreq_rise = ry_reg[RY_SPD_REQ] && !spdreq_d_reg;

   // power stage follows the servo-on bit directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_stage_on <= 1'b0;
      end else begin
         power_stage_on <= stage_on; // see R11
      end
   end

   // target, speed and table number latched per command source setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motion.target      <= 32'h0000_0000;
         motion.speed       <= 16'h0000;
         motion.speed_valid <= 1'b0;
         motion.table_no    <= 8'h00;
         motion.accel_table <= 8'h00;
      end else begin
         if (css_digit == CSS_TABLE) begin
            motion.table_no    <= ww_reg[WW_POS_LO][7:0]; // see R5
            motion.speed_valid <= 1'b0;                   // see R10
         end else begin
            if (posreq_rise) begin
               motion.target <= {ww_reg[WW_POS_HI], ww_reg[WW_POS_LO]}; // see R6
            end
            if (css_digit == CSS_POS) begin
               motion.table_no    <= ww_reg[WW_SPEED][7:0]; // see R7
               motion.speed_valid <= 1'b0;
            end else if (css_digit == CSS_SPEED && spdreq_rise) begin
               motion.speed       <= ww_reg[WW_SPEED]; // see R8
               motion.speed_valid <= 1'b1;
            end
         end
         motion.accel_table <= (css_digit == CSS_SPEED) ? ACCEL_TABLE_ENTRY
                                                        : motion.table_no; // see R9
      end
   end

   // one-shot moves and home returns, level jog, all gated by the stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motion.move_start <= 1'b0;
         motion.move_rev   <= 1'b0;
         motion.move_abs   <= 1'b0;
         motion.home_start <= 1'b0;
         motion.home_fast  <= 1'b0;
         motion.jog_fwd    <= 1'b0;
         motion.jog_rev    <= 1'b0;
      end else begin
         motion.move_start <= 1'b0;
         motion.home_start <= 1'b0;
         motion.home_fast  <= 1'b0;
         motion.jog_fwd    <= 1'b0;
         motion.jog_rev    <= 1'b0;
         if (stage_on) begin
            case (op_mode)
               SRCM_OP_AUTO: begin
                  if (fwd_rise) begin
                     motion.move_start <= 1'b1;      // see R12
                     motion.move_rev   <= 1'b0;      // see R15
                     motion.move_abs   <= !inc_mode;
                  end else if (rev_rise && inc_mode) begin
                     motion.move_start <= 1'b1;      // see R16
                     motion.move_rev   <= 1'b1;
                     motion.move_abs   <= 1'b0;
                  end
               end
               SRCM_OP_HOME: begin
                  if (fwd_rise) begin
                     motion.home_start <= 1'b1; // see R13
                  end else if (rev_rise) begin
                     motion.home_fast <= 1'b1;  // see R18
                  end
               end
               SRCM_OP_JOG: begin
                  motion.jog_fwd <= ry_reg[RY_FWD] && !ry_reg[RY_REV]; // see R14
                  motion.jog_rev <= ry_reg[RY_REV] && !ry_reg[RY_FWD]; // see R17
               end
               default: begin
                  motion.move_start <= 1'b0;
               end
            endcase
         end
      end
   end

   // remote input bits: ready, movement end and instruction completions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_reg <= 32'h0000_0000;
      end else begin
         rx_reg[RX_READY]    <= stage_on;
         rx_reg[RX_MOVE_END] <= status.move_end;
         // completion holds while the request stays on; a fresh edge wins
         if (posreq_rise && css_digit != CSS_TABLE) begin
            rx_reg[RX_POS_DONE] <= 1'b1; // see R19
         end else if (!ry_reg[RY_POS_REQ]) begin
            rx_reg[RX_POS_DONE] <= 1'b0;
         end
         if (spdreq_rise && css_digit == CSS_SPEED) begin
            rx_reg[RX_SPD_DONE] <= 1'b1;
         end else if (!ry_reg[RY_SPD_REQ]) begin
            rx_reg[RX_SPD_DONE] <= 1'b0;
         end
      end
   end

endmodule

// ===== tb/srcm_core_properties.sv
// srcm_core_properties: port-level checks bound into srcm_core.
// assumes station_no holds still after reset and transfers have an idle gap.
`timescale 1ns/100ps
module srcm_core_properties
   import srcm_pkg::*;
(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pslverr,
   input wire logic [STATION_W-1:0] station_no,
   input wire srcm_status_t         status,
   input wire logic                 power_stage_on,
   input wire logic [15:0]          mon1_code,
   input wire srcm_motion_t         motion
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       acc;
   logic       hit;
   logic [4:0] wi;
   // access phase decode inside this station window
   assign acc = psel && penable;
   assign hit = !paddr[11] && paddr[10:7] == station_no;
   assign wi  = paddr[6:2];
   mon1_split_a: assert property (
      acc && !pwrite && hit && wi == 5'h09 |-> prdata == {16'h0000, $past(status.mon1_data[31:16], 2)})
      else $error("monitor 1 upper half wrong");
   mon2_split_a: assert property (
      acc && !pwrite && hit && wi == 5'h0D |-> prdata == {16'h0000, $past(status.mon2_data[15:0], 2)})
      else $error("monitor 2 lower half wrong");
   window_err_a: assert property (acc && (!hit || wi >= 5'h14) |-> pslverr)
      else $error("unmapped access not refused");
   code_write_a: assert property (acc && pwrite && hit && wi == 5'h00 |=> mon1_code == $past(pwdata[15:0]))
      else $error("monitor code word not stored");
   power_follow_a: assert property (
      acc && pwrite && hit && wi == 5'h10 |-> ##2 power_stage_on == $past(pwdata[0], 2))
      else $error("power stage does not follow bit");
   start_power_a: assert property (motion.move_start || motion.home_start |-> power_stage_on)
      else $error("start without power stage");
   move_once_a: assert property (motion.move_start |=> !motion.move_start)
      else $error("move pulse longer than one cycle");
   home_once_a: assert property (motion.home_start |=> !motion.home_start)
      else $error("home pulse longer than one cycle");
   jog_excl_a: assert property (!(motion.jog_fwd && motion.jog_rev))
      else $error("jog in both directions");
endmodule

bind srcm_core srcm_core_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pslverr, .station_no, .status, .power_stage_on, .mon1_code, .motion);

// ===== tb/srcm_motion_model.sv
// srcm_motion_model: motion controller at the far side of srcm_core.
// assumes same-clock levels; monitor values are derived from the codes.
`timescale 1ns/100ps
module srcm_motion_model
   import srcm_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [15:0]  mon1_code,
   input  wire logic [15:0]  mon2_code,
   input  wire srcm_motion_t motion,
   output srcm_status_t      status
);
   // monitor values with distinct halves, move end while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status.mon1_data <= {~mon1_code, mon1_code};
         status.mon2_data <= {mon2_code, ~mon2_code};
         status.resp_code <= 16'h0000;
         status.read_data <= 16'h0000;
         status.move_end  <= !(motion.move_start || motion.jog_fwd || motion.jog_rev);
      end
   end
endmodule

// ===== tb/servo_remote_command_map_bench.sv
// servo_remote_command_map_bench: APB-driven self-checking bench for srcm_core.
// assumes zero-wait APB and the motion model on the far side.
`timescale 1ns/100ps
module servo_remote_command_map_bench import srcm_pkg::*;;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0]        paddr = '0;
   logic [31:0]        pwdata = '0, prdata, seed = 32'h9640, c, p, s, q;
   logic               pready, pslverr, e, power_stage_on;
   logic [3:0]         station_no = '0;
   logic [15:0]        mon1_code, mon2_code, instr_code, instr_wdata, row;
   srcm_status_t       status;
   srcm_motion_t       motion;
   int                 num_errors = 0, cmp_count = 0, cyc = 0, n[5], ok;
   logic [15:0]        rows[7] = '{16'h4310, 16'h4518, 16'h0314, 16'h0500, 16'h1302, 16'h5302, 16'h1501};
   logic [3:0]         jogs[3] = '{4'h3, 4'h7, 4'h5};

   always #5 pclk = ~pclk;
   srcm_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .station_no, .status, .power_stage_on, .mon1_code, .mon2_code, .instr_code, .instr_wdata, .motion);
   srcm_motion_model i_model (.pclk, .presetn, .mon1_code, .mon2_code, .motion, .status);

   // pulse counters and hang limit
   always @(posedge pclk) begin
      n[0] += motion.move_start;
      n[1] += motion.move_start & motion.move_rev;
      n[2] += motion.move_start & motion.move_abs;
      n[3] += motion.home_start;
      n[4] += motion.home_fast;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] ra(input logic [4:0] i);
      return {1'b0, station_no, i, 2'b00};
   endfunction
   task automatic chk(input logic t, input string m);
      cmp_count++;
      if (t !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask
   // one APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [4:0] i, input logic [31:0] d);
      apb(1, ra(i), d);
   endtask
   task automatic rd(input logic [4:0] i, input logic [31:0] x, input string m);
      apb(0, ra(i), 32'h0000_0000);
      chk(q === x && e === 1'b0, m);
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      c = rnd();
      station_no = c[3:0];
      repeat (16) @(posedge pclk);
      chk(power_stage_on === 1'b0 && motion === '0, "outputs not clear in reset");
      presetn <= 1;
      repeat (4) @(posedge pclk);
      // random monitor codes, both halves of both monitors
      for (int k = 0; k < 4; k++) begin
         c = rnd();
         wr(0, {16'h0000, c[15:0]});
         wr(1, {16'h0000, c[31:16]});
         rd(8, {16'h0000, c[15:0]}, "monitor 1 low");
         rd(9, {16'h0000, ~c[15:0]}, "monitor 1 high");
         rd(13, {16'h0000, ~c[31:16]}, "monitor 2 low");
         rd(14, {16'h0000, c[31:16]}, "monitor 2 high");
      end
      // instruction words pass straight to the driver core
      wr(2, {16'h0000, c[31:16]});
      wr(3, {16'h0000, c[15:0]});
      @(posedge pclk);
      chk(instr_code === c[31:16] && instr_wdata === c[15:0], "instruction words");
      // refused places and a foreign station
      apb(0, ra(5'h15), 32'h0000_0000);
      chk(e === 1'b1 && q === 32'h0000_0000, "unmapped read accepted");
      apb(1, {1'b0, station_no + 4'h1, 5'h10, 2'b00}, 32'h0000_0003);
      repeat (3) @(posedge pclk);
      chk(e === 1'b1 && power_stage_on === 1'b0, "foreign station write taken");
      // each low digit of the command source setting
      for (int dg = 0; dg < 3; dg++) begin
         p = rnd();
         s = rnd();
         wr(18, dg);
         wr(4, {16'h0000, p[15:0]});
         wr(5, {16'h0000, p[31:16]});
         wr(6, {16'h0000, s[15:0]});
         // both requests each time: digit 0 must ignore them
         c = (dg == 0) ? 32'h0000_1000 : (dg == 1) ? 32'h0001_1000 : 32'h0003_1000;
         wr(16, 32'h0003_0000);
         repeat (3) @(posedge pclk);
         if (dg == 0)
            chk(motion.table_no === p[7:0] && motion.speed === 16'h0000 && motion.speed_valid === 1'b0
               && motion.target === 32'h0000_0000, "digit 0");
         else if (dg == 1)
            chk(motion.target === p && motion.table_no === s[7:0], "digit 1");
         else
            chk(motion.target === p && motion.speed === s[15:0] && motion.speed_valid === 1'b1
               && motion.accel_table === 8'h01, "digit 2");
         rd(17, c, "completion bits");
         wr(16, 0);
      end
      // start without power
      wr(19, 4);
      n = '{0, 0, 0, 0, 0};
      wr(16, 2);
      repeat (8) @(posedge pclk);
      chk(n[0] == 0 && power_stage_on === 1'b0, "move without power");
      // start bits per mode, held to show a single launch
      foreach (rows[r]) begin
         row = rows[r];
         wr(16, 1);
         wr(19, row[15:12]);
         n = '{0, 0, 0, 0, 0};
         wr(16, row[11:8] | 4'h1);
         repeat (8) @(posedge pclk);
         ok = 1;
         for (int j = 0; j < 5; j++)
            ok &= (n[j] == row[4 - j]);
         chk(ok == 1, "start pulse counts");
      end
      rd(17, 32'h0000_1001, "ready bit");
      // jog levels while held
      wr(19, 2);
      foreach (jogs[j]) begin
         wr(16, jogs[j]);
         repeat (3) @(posedge pclk);
         chk(motion.jog_fwd === (jogs[j] == 3) && motion.jog_rev === (jogs[j] == 5), "jog level");
      end
      wr(16, 0);
      repeat (3) @(posedge pclk);
      chk(power_stage_on === 1'b0 && !motion.jog_rev && !motion.jog_fwd, "power off");
      complete_run();
   end
endmodule
